/* File: design/cps_pkg.sv */
// Shared constants and types for the configuration port and set switch
package cps_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TDIG_NS       = 1000;
    localparam int TDIG_CYC      = (TDIG_NS / CLK_PERIOD_NS < 1) ? 1 : TDIG_NS / CLK_PERIOD_NS;
    // ==========================================================
    // Register map and fields
    localparam int         ADDR_W      = 5;
    localparam int         REG_COUNT   = 32;
    localparam logic [4:0] SET_A_CTRL  = 5'h03;
    localparam logic [4:0] SET_B_CTRL  = 5'h13;
    localparam int         SEL_BIT     = 7;
    localparam int         STATUS_BIT  = 6;
    localparam int         LOW_VOLTAGE_DETECT_ENABLE_BIT    = 1;
    localparam int         SOE_BIT     = 0;
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic       STATUS_RST  = 1'b1;
    // ==========================================================
    // Command byte layout
    localparam int CMD_CNT_HI  = 7;
    localparam int CMD_CNT_LO  = 6;
    localparam int CMD_ADDR_HI = 5;
    localparam int CMD_ADDR_LO = 1;
    localparam int CMD_RW_BIT  = 0;
    // ==========================================================
    // Pin indices of the synchroniser vector
    localparam int N_PIN    = 5;
    localparam int PIN_CS   = 0;
    localparam int PIN_WAKE = 1;
    localparam int PIN_SEN  = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_MOSI = 4;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_LVD     = 4'h2,
        ST_CONFIG  = 4'h4,
        ST_RECEIVE = 4'h8
    } cps_mode_t;
endpackage

/* File: design/cps_spi_if.sv */
// Link between the control core and the SPI shifter
`timescale 1ns/100ps
interface cps_spi_if;
    logic       active;
    logic       sclk_fall;
    logic       mosi;
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       byte_valid;
    logic [7:0] rx_byte;
    logic       miso;

    modport shifter (input active, sclk_fall, mosi, tx_load, tx_byte,
                     output byte_valid, rx_byte, miso);
    modport core    (output active, sclk_fall, mosi, tx_load, tx_byte,
                     input byte_valid, rx_byte, miso);
endinterface

/* File: design/cps_spi_shift.sv */
// SPI byte shifter for the configuration port
`timescale 1ns/100ps
module cps_spi_shift
    import cps_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    cps_spi_if.shifter spi
);
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] sin_reg,     sin_next;
    logic [7:0] sout_reg,    sout_next;
    logic       valid_reg,   valid_next;

    // ==========================================================
    // Shifting
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        sin_next     = sin_reg;
        sout_next    = sout_reg;
        valid_next   = 1'b0;
        if (!spi.active) begin
            bit_cnt_next = 3'h0; // Partial byte dropped, see [RQ10]
        end else begin
            if (spi.sclk_fall) begin
                sin_next     = {sin_reg[6:0], spi.mosi};
                sout_next    = {sout_reg[6:0], 1'b0};
                bit_cnt_next = bit_cnt_reg + 3'h1;
                valid_next   = (bit_cnt_reg == 3'h7); // see [RQ10]
            end
            if (spi.tx_load) begin
                sout_next = spi.tx_byte;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_reg <= 3'h0;
            sin_reg     <= 8'h00;
            sout_reg    <= 8'h00;
            valid_reg   <= 1'b0;
        end else if (ce_i) begin
            bit_cnt_reg <= bit_cnt_next;
            sin_reg     <= sin_next;
            sout_reg    <= sout_next;
            valid_reg   <= valid_next;
        end
    end

    assign spi.byte_valid = valid_reg;
    assign spi.rx_byte    = sin_reg;
    assign spi.miso       = sout_reg[7];

    a_byte_on_eighth: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see [RQ10]
        (ce_i && spi.active && spi.sclk_fall && bit_cnt_reg == 3'h7) |=> valid_reg)
        else $error("byte not taken on eighth falling edge");
endmodule

/* File: design/cps_top.sv */
// Configuration port, power mode control and register set switching
`timescale 1ns/100ps
// Functional notes
// [RQ1] Deselected with wake low: standby, no output, input ignored until config mode.
// [RQ2] Standby sits idle with detect disabled; with it enabled runs low voltage detect.
// [RQ3] Standby or detect mode left only by select low and wake high.
// [RQ4] Select low and wake high: host drives clock and MOSI, device drives MISO.
// [RQ5] Transfers are bytes; first byte after select falling edge is the command.
// [RQ6] Command: bits 7-6 count code, bits 5-1 first address, bit 0 direction.
// [RQ7] Count code 00,01,10,11 gives one, two, four, eight registers.
// [RQ8] Address starts at command address and steps after each data byte.
// [RQ9] Direction 0 returns data on MISO; 1 takes write data from MOSI.
// [RQ10] Byte taken on eighth falling clock edge; trailing partial bits dropped.
// [RQ11] Host separates accesses by select pulses; short gaps keep config mode.
// [RQ12] Config mode changes neither registers nor receiver on/off; no reception there. Code: SPI data bytes write registers in config mode.
// [RQ13] Host pulses select low one internal period to leave receive mode.
// [RQ14] Host wakes device past lock times before programming registers.
// [RQ15] Set B selected only when primary 0 and secondary 1; both 1 alternate.
// [RQ16] Read-only set status bit reads same from both sets, shows active set.
// [RQ17] Direct control: new set takes effect when select returns high.
// [RQ18] Pin control: wake high turns receiver on with selected set, low off.
// [RQ19] Only set A selected reports status 1; only set B reports 0.
// [RQ20] Both selected under pin control: status toggles at each wake falling edge.
// [RQ21] A message in progress holds the on-state until it ends.
// [RQ22] After any SPI access the alternating sequence restarts with set A.
// [RQ23] Strobe control: status toggles at each on-state end, frozen if wake forced.
// [RQ24] MISO idle on writes or when deselected; driven only in read data bytes.
// [RQ25] Register address wraps within five bits.
module cps_top
    import cps_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic config_select_n_i,
    input  wire logic wake_control_i,
    input  wire logic spi_enable_n_i,
    input  wire logic sclk_i,
    input  wire logic mosi_i,
    input  wire logic message_active_i,
    input  wire logic strobe_on_end_i,
    output logic      miso_o,
    output logic      miso_oe_n_o,
    output logic      rx_on_o,
    output logic      active_set_status_o,
    output logic      standby_o,
    output logic      lvd_active_o,
    output logic      config_mode_o,
    output logic      receive_mode_o,
    output logic      strobe_osc_enable_o,
    output logic      low_voltage_detect_enable_o
);
    // ==========================================================
    // Pin synchronisers
    logic [N_PIN-1:0] pin_vec, s1_reg, s2_reg, s3_reg;
    assign pin_vec = {mosi_i, sclk_i, spi_enable_n_i, wake_control_i, config_select_n_i};

    genvar g;
    generate
        for (g = 0; g < N_PIN; g++) begin : g_sync
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_reg[g] <= 1'b1;
                    s2_reg[g] <= 1'b1;
                    s3_reg[g] <= 1'b1;
                end else if (ce_i) begin
                    s1_reg[g] <= pin_vec[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                end
            end
        end
    endgenerate

    logic cs_n, wake, cs_fall;
    assign cs_n      = s2_reg[PIN_CS];
    assign wake      = s2_reg[PIN_WAKE];
    assign cs_fall   = s3_reg[PIN_CS] & ~cs_n;

    // ==========================================================
    // Register sets and status
    logic [7:0] regs [REG_COUNT];
    logic       status_reg, status_next;
    logic       prim_sel, sec_sel, strobe_osc_enable, low_voltage_detect_enable, both_sel;
    assign prim_sel = regs[SET_A_CTRL][SEL_BIT];
    assign sec_sel  = regs[SET_B_CTRL][SEL_BIT];
    assign strobe_osc_enable      = regs[SET_A_CTRL][SOE_BIT];
    assign low_voltage_detect_enable     = regs[SET_A_CTRL][LOW_VOLTAGE_DETECT_ENABLE_BIT];
    assign both_sel = prim_sel & sec_sel; // see [RQ15]

    function automatic logic [7:0] rd_reg(input logic [4:0] a);
        logic [7:0] d;
        d = regs[a];
        if (a == SET_A_CTRL || a == SET_B_CTRL) begin
            d[STATUS_BIT] = status_reg; // see [RQ16]
        end
        return d;
    endfunction

    // ==========================================================
    // SPI command and data handling
    cps_spi_if spi ();
    cps_spi_shift u_shift (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .spi       (spi)
    );

    cps_mode_t  state_reg, state_next;
    logic       cmd_pend_reg, cmd_pend_next;
    logic [3:0] cnt_reg,      cnt_next;
    logic [4:0] addr_reg,     addr_next;
    logic       wr_reg,       wr_next;
    logic       load_reg,     load_next;
    logic [7:0] txb_reg,      txb_next;
    logic       acc_reg,      acc_next;
    logic       we;

    // Only a selected, awake device in config mode listens; see [RQ1] [RQ4]
    assign spi.active    = (state_reg == ST_CONFIG) & ~cs_n & wake & ~s2_reg[PIN_SEN];
    assign spi.sclk_fall = s3_reg[PIN_SCLK] & ~s2_reg[PIN_SCLK];
    assign spi.mosi      = s2_reg[PIN_MOSI];
    assign spi.tx_load   = load_reg;
    assign spi.tx_byte   = txb_reg;

    always_comb begin
        cmd_pend_next = cmd_pend_reg;
        cnt_next      = cnt_reg;
        addr_next     = addr_reg;
        wr_next       = wr_reg;
        load_next     = 1'b0;
        txb_next      = txb_reg;
        acc_next      = acc_reg;
        we            = 1'b0;
        if (cs_fall) begin
            cmd_pend_next = 1'b1; // see [RQ5]
            cnt_next      = 4'h0;
        end else if (spi.byte_valid && cmd_pend_reg) begin
            cmd_pend_next = 1'b0;
            cnt_next  = 4'h1 << spi.rx_byte[CMD_CNT_HI:CMD_CNT_LO]; // see [RQ6] [RQ7]
            addr_next = spi.rx_byte[CMD_ADDR_HI:CMD_ADDR_LO]; // see [RQ6]
            wr_next   = spi.rx_byte[CMD_RW_BIT]; // see [RQ9]
            load_next = ~spi.rx_byte[CMD_RW_BIT];
            txb_next  = rd_reg(spi.rx_byte[CMD_ADDR_HI:CMD_ADDR_LO]);
        end else if (spi.byte_valid && cnt_reg != 4'h0) begin
            we        = wr_reg; // see [RQ9]
            cnt_next  = cnt_reg - 4'h1;
            addr_next = addr_reg + 5'h01; // Natural 5-bit wrap, see [RQ8] [RQ25]
            acc_next  = 1'b1; // see [RQ22]
            load_next = ~wr_reg & (cnt_reg != 4'h1);
            txb_next  = rd_reg(addr_reg + 5'h01);
        end
        if (state_reg != ST_CONFIG) begin
            acc_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_pend_reg <= 1'b0;
            cnt_reg      <= 4'h0;
            addr_reg     <= 5'h00;
            wr_reg       <= 1'b0;
            load_reg     <= 1'b0;
            txb_reg      <= 8'h00;
            acc_reg      <= 1'b0;
        end else if (ce_i) begin
            cmd_pend_reg <= cmd_pend_next;
            cnt_reg      <= cnt_next;
            addr_reg     <= addr_next;
            wr_reg       <= wr_next;
            load_reg     <= load_next;
            txb_reg      <= txb_next;
            acc_reg      <= acc_next;
        end
    end

    // Writes land only from SPI data bytes; status bit stays read-only
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RST;
            end
        end else if (ce_i && we) begin
            if (addr_reg == SET_A_CTRL || addr_reg == SET_B_CTRL) begin
                regs[addr_reg] <= spi.rx_byte & ~(8'h01 << STATUS_BIT); // see [RQ16]
            end else begin
                regs[addr_reg] <= spi.rx_byte; // Plain storage, see [RQ12]
            end
        end
    end

    // ==========================================================
    // Mode control
    logic [7:0] gap_reg, gap_next;
    logic       rx_on_next, miso_next, oe_n_next;

    always_comb begin
        state_next  = state_reg;
        gap_next    = 8'h00;
        rx_on_next  = rx_on_o;
        status_next = status_reg;
        case (state_reg)
            ST_STANDBY, ST_LVD: begin
                rx_on_next = 1'b0;
                state_next = low_voltage_detect_enable ? ST_LVD : ST_STANDBY; // see [RQ2]
                if (!cs_n && wake) begin
                    state_next = ST_CONFIG; // see [RQ3]
                end
            end
            ST_CONFIG: begin
                // Receiver state frozen here, see [RQ12]
                if (cs_n && wake) begin
                    state_next = ST_RECEIVE;
                end else if (cs_n) begin
                    // Short deselect gaps tolerated, see [RQ11]
                    gap_next = gap_reg + 8'h01;
                    if (gap_reg == 8'(TDIG_CYC - 1)) begin
                        state_next = low_voltage_detect_enable ? ST_LVD : ST_STANDBY; // see [RQ1]
                    end
                end
                if (state_next != ST_CONFIG) begin
                    // New selection applies on leaving, see [RQ17] [RQ19]
                    if (!sec_sel) begin
                        status_next = 1'b1;
                    end else if (!prim_sel) begin
                        status_next = 1'b0;
                    end else if (acc_reg) begin
                        status_next = 1'b1; // see [RQ22]
                    end
                    if (state_next != ST_RECEIVE) begin
                        rx_on_next = 1'b0;
                    end
                end
            end
            ST_RECEIVE: begin
                if (!cs_n) begin
                    state_next = ST_CONFIG; // see [RQ13]
                end else begin
                    // Wake level gates receiver, message extends it; see [RQ18] [RQ21]
                    rx_on_next = wake | (rx_on_o & message_active_i);
                    if (both_sel && !strobe_osc_enable && rx_on_o && !rx_on_next) begin
                        status_next = ~status_reg; // see [RQ20]
                    end
                    if (both_sel && strobe_osc_enable && strobe_on_end_i && !wake) begin
                        status_next = ~status_reg; // see [RQ23]
                    end
                end
            end
            default: begin
                state_next = ST_STANDBY;
            end
        endcase
        // MISO only in read data bytes, see [RQ24] [RQ9]
        oe_n_next = ~(spi.active & ~wr_reg & ~cmd_pend_reg & (cnt_reg != 4'h0));
        miso_next = oe_n_next ? 1'b0 : spi.miso;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= ST_STANDBY;
            gap_reg     <= 8'h00;
            rx_on_o     <= 1'b0;
            status_reg  <= STATUS_RST;
            miso_o      <= 1'b0;
            miso_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            state_reg   <= state_next;
            gap_reg     <= gap_next;
            rx_on_o     <= rx_on_next;
            status_reg  <= status_next;
            miso_o      <= miso_next;
            miso_oe_n_o <= oe_n_next;
        end
    end

    assign active_set_status_o         = status_reg;
    assign standby_o                   = state_reg[0];
    assign lvd_active_o                = state_reg[1];
    assign config_mode_o               = state_reg[2];
    assign receive_mode_o              = state_reg[3];
    assign strobe_osc_enable_o         = strobe_osc_enable;
    assign low_voltage_detect_enable_o = low_voltage_detect_enable;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_low_power;
        state_reg == ST_STANDBY || state_reg == ST_LVD;
    endsequence
    sequence s_woken;
        ce_i && !(state_reg == ST_STANDBY || state_reg == ST_LVD);
    endsequence

    a_standby_quiet: assert property (s_low_power |-> miso_oe_n_o && !rx_on_o) // see [RQ1]
        else $error("output active in standby");
    a_lvd_follows_en: assert property ((state_reg == ST_LVD) |-> $past(low_voltage_detect_enable)) // see [RQ2]
        else $error("detect mode without enable");
    a_exit_to_config: assert property (s_low_power ##1 s_woken |-> config_mode_o) // see [RQ3]
        else $error("standby left other than to config");
    a_cmd_decode: assert property ((ce_i && spi.byte_valid && cmd_pend_reg && !cs_fall) // see [RQ6]
        |=> cnt_reg == (4'h1 << $past(spi.rx_byte[7:6])) && addr_reg == $past(spi.rx_byte[5:1]))
        else $error("command byte decoded wrongly");
    a_addr_step: assert property ((ce_i && spi.byte_valid && !cmd_pend_reg && !cs_fall // see [RQ8]
        && cnt_reg != 4'h0) |=> addr_reg == $past(addr_reg) + 5'h01)
        else $error("address did not step by one");
    a_config_rx_hold: assert property (config_mode_o && !$past(receive_mode_o) // see [RQ12]
        |=> $stable(rx_on_o) || !rx_on_o)
        else $error("receiver switched on in config mode");
    a_set_a_status: assert property ((receive_mode_o && !sec_sel) |-> status_reg) // see [RQ19]
        else $error("set A not reported");
    a_pin_toggle: assert property ((ce_i && receive_mode_o && both_sel && !strobe_osc_enable && rx_on_o // see [RQ20]
        && !wake && !message_active_i && cs_n) |=> status_reg != $past(status_reg))
        else $error("status did not toggle on wake fall");
    a_msg_hold: assert property ((receive_mode_o && rx_on_o && message_active_i) // see [RQ21]
        |=> rx_on_o)
        else $error("on-state dropped during message");
    a_miso_idle: assert property ((cs_n || wr_reg) |=> miso_oe_n_o) // see [RQ24]
        else $error("MISO driven outside read");
endmodule

/* File: sim/cps_host_model.sv */
// Host controller model that drives the configuration port pins
`timescale 1ns/100ps
module cps_host_model (
    output logic      config_select_n_o,
    output logic      wake_control_o,
    output logic      spi_enable_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i
);
    // ==========================================================
    // Idle pin levels: SCLK stands high outside frames
    initial begin
        config_select_n_o = 1'b1;
        wake_control_o    = 1'b0;
        spi_enable_n_o    = 1'b1;
        sclk_o            = 1'b1;
        mosi_o            = 1'b0;
    end
    // ==========================================================
    // Framing
    task automatic set_wake(input logic w);
        wake_control_o = w;
    endtask
    // Awake receiver: short select pulse first resets only the state machine
    task automatic open_access(input logic w);
        if (wake_control_o && w) begin
            config_select_n_o = 1'b0;
            #(cps_pkg::TDIG_NS);
            config_select_n_o = 1'b1;
            #2000;
        end
        wake_control_o = w;
        #200;
        config_select_n_o = 1'b0;
        spi_enable_n_o    = 1'b0;
        #400;
    endtask
    task automatic close_access(input logic w);
        #400;
        wake_control_o    = w;
        config_select_n_o = 1'b1;
        spi_enable_n_o    = 1'b1;
        mosi_o            = ~mosi_o;
        #400;
    endtask
    // MSB first; MISO taken while SCLK is high, before the shifting fall
    task automatic shift_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            mosi_o = tx[i];
            rx[i]  = miso_oe_n_i ? 1'bx : miso_i;
            #80 sclk_o = 1'b0;
            #160 sclk_o = 1'b1;
            #80;
        end
    endtask
endmodule

/* File: sim/test_cps_top.sv */
// Self-checking bench for the configuration port and set switch
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_cps_top
    import cps_pkg::*;
;
    logic       ref_clk_i, rst_i, ce, msg_i, strobe_end_i, wr_on;
    logic       sel_n, wake, spi_en_n, sclk, mosi;
    logic       miso_o, miso_oe_n_o, rx_on_o, active_set_status_o, standby_o, lvd_active_o;
    logic       config_mode_o, receive_mode_o, strobe_osc_enable_o, low_voltage_detect_enable_o;
    logic [7:0] mem [32];
    int         n_mismatch, total_checks, cycles, seed;

    cps_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .config_select_n_i(sel_n),
        .wake_control_i(wake), .spi_enable_n_i(spi_en_n), .sclk_i(sclk), .mosi_i(mosi),
        .message_active_i(msg_i), .strobe_on_end_i(strobe_end_i), .miso_o(miso_o),
        .miso_oe_n_o(miso_oe_n_o), .rx_on_o(rx_on_o), .active_set_status_o(active_set_status_o),
        .standby_o(standby_o), .lvd_active_o(lvd_active_o), .config_mode_o(config_mode_o),
        .receive_mode_o(receive_mode_o), .strobe_osc_enable_o(strobe_osc_enable_o),
        .low_voltage_detect_enable_o(low_voltage_detect_enable_o));
    cps_host_model host (.config_select_n_o(sel_n), .wake_control_o(wake), .spi_enable_n_o(spi_en_n),
        .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o));

    // ==========================================================
    // Clock, watchdog and verdict
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            $display("ERROR watchdog expired");
            print_verdict();
        end
    end
    always @(negedge ref_clk_i) if (wr_on) `CHK("miso enable", 1'b1, miso_oe_n_o)
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Helpers
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Status and control registers are kept out of random bursts
    function automatic bit hits(input logic [4:0] a, input int n);
        hits = 1'b0;
        for (int k = 0; k < n; k++) if (5'(a + k) inside {SET_A_CTRL, SET_B_CTRL}) hits = 1'b1;
    endfunction
    task automatic wr(input logic [4:0] a, input logic [1:0] code, input int extra,
                      input logic [8:0] fix, input logic wake_end);
        logic [7:0] d, rx;
        host.open_access(1'b1);
        wr_on = 1'b1;
        host.shift_bits({code, a, 1'b1}, 8, rx);
        for (int k = 0; k < (1 << code) + extra; k++) begin
            d = fix[8] ? fix[7:0] : 8'($random(seed));
            if (k < (1 << code)) mem[5'(a + k)] = d;
            host.shift_bits(d, 8, rx);
        end
        host.shift_bits(8'hff, 7, rx);
        wr_on = 1'b0;
        host.close_access(wake_end);
    endtask
    task automatic rd(input logic [4:0] a, input logic [1:0] code);
        logic [7:0] rx;
        host.open_access(1'b1);
        host.shift_bits({code, a, 1'b0}, 8, rx);
        for (int k = 0; k < (1 << code); k++) begin
            host.shift_bits(8'h00, 8, rx);
            `CHK("read data", mem[5'(a + k)], rx)
        end
        host.close_access(1'b1);
        `CHK("miso idle", 1'b1, miso_oe_n_o)
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [4:0] a;
        logic [1:0] code;
        logic [7:0] rx;
        seed = 89571;
        n_mismatch = 0;
        total_checks = 0;
        cycles = 0;
        rst_i = 1'b1;
        ce = 1'b1;
        msg_i = 1'b0;
        strobe_end_i = 1'b0;
        wr_on = 1'b0;
        foreach (mem[i]) mem[i] = REG_RST;
        repeat (16) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_i = 1'b0;
        `CHK("standby after reset", 1'b1, standby_o)
        `CHK("status after reset", STATUS_RST, active_set_status_o)
        // Wrapping burst with a byte beyond the count
        wr(5'd26, 2'b11, 1, 9'h000, 1'b1);
        rd(5'd26, 2'b11);
        rd(5'd2, 2'b00);
        `CHK("receive mode", 1'b1, receive_mode_o)
        `CHK("set a status", 1'b1, active_set_status_o)
        for (int t = 0; t < 8; t++) begin
            code = 2'(t);
            do a = 5'($random(seed)); while (hits(a, (1 << code) + 1));
            wr(a, code, 1, 9'h000, 1'b1);
            rd(a, code);
        end
        // Set B alone, receiver follows the wake pin; all state frozen while enable is low
        wr(SET_B_CTRL, 2'b00, 0, 9'h180, 1'b1);
        `CHK("set b status", 1'b0, active_set_status_o)
        `CHK("rx on", 1'b1, rx_on_o)
        ce = 1'b0;
        host.set_wake(1'b0);
        wt(8);
        `CHK("rx frozen", 1'b1, rx_on_o)
        ce = 1'b1;
        wt(8);
        `CHK("rx off", 1'b0, rx_on_o)
        // Both sets under pin control
        wr(SET_A_CTRL, 2'b00, 0, 9'h180, 1'b1);
        `CHK("restart on a", 1'b1, active_set_status_o)
        host.set_wake(1'b0);
        wt(8);
        `CHK("toggle on fall", 1'b0, active_set_status_o)
        host.set_wake(1'b1);
        msg_i = 1'b1;
        wt(8);
        host.set_wake(1'b0);
        wt(8);
        `CHK("held by message", 1'b1, rx_on_o)
        `CHK("status held", 1'b0, active_set_status_o)
        msg_i = 1'b0;
        wt(8);
        `CHK("message end", 2'b01, {rx_on_o, active_set_status_o})
        host.set_wake(1'b1);
        wt(8);
        host.set_wake(1'b0);
        wt(8);
        // Wake drop inside config mode must not switch the receiver off
        host.open_access(1'b1);
        host.set_wake(1'b0);
        wt(8);
        `CHK("config mode", 1'b1, config_mode_o)
        `CHK("rx kept in config", 1'b1, rx_on_o)
        host.close_access(1'b1);
        rd(5'd0, 2'b00);
        `CHK("restart after read", 1'b1, active_set_status_o)
        // Status bit reads the same from both sets
        mem[SET_A_CTRL][STATUS_BIT] = 1'b1;
        mem[SET_B_CTRL][STATUS_BIT] = 1'b1;
        rd(SET_A_CTRL, 2'b00);
        rd(SET_B_CTRL, 2'b00);
        // Strobe oscillator control, receiver awake then wake released
        wr(SET_A_CTRL, 2'b00, 0, 9'h181, 1'b1);
        `CHK("strobe enable", 1'b1, strobe_osc_enable_o)
        host.set_wake(1'b0);
        wt(4);
        strobe_end_i = 1'b1;
        wt(1);
        strobe_end_i = 1'b0;
        wt(4);
        `CHK("strobe toggle", 1'b0, active_set_status_o)
        host.set_wake(1'b1);
        wt(8);
        strobe_end_i = 1'b1;
        wt(1);
        strobe_end_i = 1'b0;
        wt(4);
        `CHK("strobe frozen", 1'b0, active_set_status_o)
        // Detect mode, traffic ignored until config mode returns
        wr(SET_A_CTRL, 2'b00, 0, 9'h102, 1'b0);
        wt(40);
        `CHK("detect enable", 1'b1, low_voltage_detect_enable_o)
        `CHK("detect mode", 1'b1, lvd_active_o)
        host.open_access(1'b0);
        host.shift_bits(8'h01, 8, rx);
        `CHK("no config", 1'b0, config_mode_o)
        `CHK("silent in detect", 1'b1, miso_oe_n_o)
        host.shift_bits(8'h5a, 8, rx);
        host.close_access(1'b0);
        rd(5'd0, 2'b00);
        wr(SET_A_CTRL, 2'b00, 0, 9'h100, 1'b0);
        wt(40);
        `CHK("plain standby", 2'b10, {standby_o, lvd_active_o})
        print_verdict();
    end
endmodule
